// ### logic/port_override_pkg.sv
package port_override_pkg;
  // Avalon register map (word byte addresses)
  localparam logic [3:0] DIR_OFFSET      = 4'h0;
  localparam logic [3:0] OUT_OFFSET      = 4'h4;
  localparam logic [3:0] PIN_OFFSET      = 4'h8;
  localparam logic [3:0] CTRL_OFFSET     = 4'hc;
  // Control register fields
  localparam int CTRL_PUD_BIT            = 0;
  localparam int CTRL_SLEEP_MODE_LSB     = 4;
  localparam int CTRL_SLEEP_MODE_W       = 3;
  // Reset values
  localparam logic [7:0] DIR_RESET       = 8'h00;
  localparam logic [7:0] OUT_RESET       = 8'h00;
  localparam logic       PUD_RESET       = 1'b0;
  // Pull-up enable pattern for {dir, out, pud}
  localparam logic [2:0] PULLUP_PATTERN  = 3'b010;
  // Sleep mode encodings
  typedef enum logic [2:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_ADC_NR,
    SLEEP_POWER_DOWN,
    SLEEP_POWER_SAVE,
    SLEEP_STANDBY
  } sleep_mode_t;
  localparam logic [2:0] SLEEP_RESET     = 3'h0;
endpackage : port_override_pkg

// ### logic/port_pin_override_logic.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module port_pin_override_logic
  import port_override_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Per-pin overrides from alternate-function modules
  input  wire logic [PIN_COUNT-1:0] pullup_override_en,
  input  wire logic [PIN_COUNT-1:0] pullup_override_val,
  input  wire logic [PIN_COUNT-1:0] drive_override_en,
  input  wire logic [PIN_COUNT-1:0] drive_override_val,
  input  wire logic [PIN_COUNT-1:0] level_override_en,
  input  wire logic [PIN_COUNT-1:0] level_override_val,
  input  wire logic [PIN_COUNT-1:0] invert_override_en,
  input  wire logic [PIN_COUNT-1:0] input_gate_override_en,
  input  wire logic [PIN_COUNT-1:0] input_gate_override_val,
  input  wire logic [PIN_COUNT-1:0] ext_int_enable,
  // Pad side
  input  wire logic [PIN_COUNT-1:0] pad_in,
  output logic      [PIN_COUNT-1:0] pad_out,
  output logic      [PIN_COUNT-1:0] pad_oe,
  output logic      [PIN_COUNT-1:0] pad_pullup,
  // To alternate-function modules
  output logic      [PIN_COUNT-1:0] alt_logic_in,
  output logic      [PIN_COUNT-1:0] pin_input_sync,
  output logic                      deep_rest_input_clamp
);

  logic [PIN_COUNT-1:0] dir_bit;
  logic [PIN_COUNT-1:0] out_value_bit;
  logic [PIN_COUNT-1:0] syncStage;
  logic [PIN_COUNT-1:0] pin_input_bit;
  logic                 global_pullup_disable;
  logic [2:0]           sleepMode;
  logic                 busy;

  logic                 clampNow;
  logic [PIN_COUNT-1:0] inputEnable;
  logic [PIN_COUNT-1:0] gatedIn;
  logic [PIN_COUNT-1:0] next_oe;
  logic [PIN_COUNT-1:0] next_out;
  logic [PIN_COUNT-1:0] next_pullup;
  logic                 wrStrobe;
  logic                 rdStrobe;
  logic [PIN_COUNT-1:0] wrData;
  logic                 laneOk;
  logic                 wrDir;
  logic                 wrOut;
  logic                 wrToggle;
  logic                 wrCtrl;
  logic [31:0]          readMux;
  logic                 next_busy;
  logic                 next_wait;

  // Strobes are shared by every pin of the port
  assign wrStrobe = write && busy;
  // Read data is captured on the first cycle so it stands when waitrequest drops
  assign rdStrobe = read && !busy;
  assign wrData   = writedata[PIN_COUNT-1:0];
  assign laneOk   = byteenable[0];
  // Decoded register writes
  assign wrDir    = wrStrobe && laneOk && (address == DIR_OFFSET);
  assign wrOut    = wrStrobe && laneOk && (address == OUT_OFFSET);
  assign wrToggle = wrStrobe && laneOk && (address == PIN_OFFSET);
  assign wrCtrl   = wrStrobe && laneOk && (address == CTRL_OFFSET);

  // Deep-sleep clamp is shared by every pin of the port
  always_comb begin
    clampNow = (sleepMode == SLEEP_POWER_DOWN) ||
               (sleepMode == SLEEP_POWER_SAVE) ||
               (sleepMode == SLEEP_STANDBY);
  end

  // One slice per pin; unused override enables must be tied low by the integrator
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    logic pinEnable;
    logic pinGated;
    logic pinOe;
    logic pinLevel;
    logic pinOut;
    logic pinPullup;
    logic plainPullup;

    // Input enable: forced by an alternate function, else awake or interrupt-enabled
    always_comb begin
      if (input_gate_override_en[p]) begin
        pinEnable = input_gate_override_val[p];
      end else if (ext_int_enable[p]) begin
        pinEnable = 1'b1;
      end else begin
        pinEnable = !clampNow;
      end
    end

    // Clamp to ground ahead of the Schmitt trigger; release on wake reads as an edge
    always_comb begin
      pinGated = pad_in[p] && pinEnable;
    end

    // Output driver enable
    always_comb begin
      if (drive_override_en[p]) begin
        pinOe = drive_override_val[p];
      end else begin
        pinOe = dir_bit[p];
      end
    end

    // Driven level
    always_comb begin
      if (level_override_en[p]) begin
        pinLevel = level_override_val[p];
      end else begin
        pinLevel = out_value_bit[p];
      end
    end

    // A disabled driver shows a quiet low
    always_comb begin
      if (pinOe) begin
        pinOut = pinLevel;
      end else begin
        pinOut = 1'b0;
      end
    end

    // Plain pull-up: input pin, output register high, pull-ups not disabled
    always_comb begin
      plainPullup = ({dir_bit[p], out_value_bit[p], global_pullup_disable} == PULLUP_PATTERN);
    end

    always_comb begin
      if (pullup_override_en[p]) begin
        pinPullup = pullup_override_val[p];
      end else begin
        pinPullup = plainPullup;
      end
    end

    assign inputEnable[p] = pinEnable;
    assign gatedIn[p]     = pinGated;
    assign next_oe[p]     = pinOe;
    assign next_out[p]    = pinOut;
    assign next_pullup[p] = pinPullup;
  end

  // One wait state: first cycle of a request asserts waitrequest
  always_comb begin
    next_busy = (read || write) && !busy;
  end

  always_comb begin
    next_wait = !next_busy;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= next_wait;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dir_bit <= DIR_RESET[PIN_COUNT-1:0];
    end else if (wrDir) begin
      dir_bit <= wrData;
    end
  end

  // Output register: software write, write-one toggle and alternate-function invert
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_value_bit <= OUT_RESET[PIN_COUNT-1:0];
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (wrOut) begin
          out_value_bit[i] <= wrData[i] ^ invert_override_en[i];
        end else if (wrToggle && wrData[i]) begin
          out_value_bit[i] <= !out_value_bit[i] ^ invert_override_en[i];
        end else if (invert_override_en[i]) begin
          out_value_bit[i] <= !out_value_bit[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      global_pullup_disable <= PUD_RESET;
    end else if (wrCtrl) begin
      global_pullup_disable <= writedata[CTRL_PUD_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleepMode <= SLEEP_RESET;
    end else if (wrCtrl) begin
      sleepMode <= writedata[CTRL_SLEEP_MODE_LSB +: CTRL_SLEEP_MODE_W];
    end
  end

  // Port synchroniser: only the second stage is read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncStage <= '0;
    end else begin
      syncStage <= gatedIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_input_bit <= '0;
    end else begin
      pin_input_bit <= syncStage;
    end
  end

  // Register read mux; unmapped offsets read as zero
  always_comb begin
    case (address)
      DIR_OFFSET:  readMux = 32'(dir_bit);
      OUT_OFFSET:  readMux = 32'(out_value_bit);
      PIN_OFFSET:  readMux = 32'(pin_input_bit);
      CTRL_OFFSET: readMux = 32'({sleepMode, 3'h0, global_pullup_disable});
      default:     readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (rdStrobe) begin
      readdata <= readMux;
    end
  end

  // Pads come up tri-stated with pull-ups off during reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_oe <= '0;
    end else begin
      pad_oe <= next_oe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_out <= '0;
    end else begin
      pad_out <= next_out;
    end
  end

  // Pull-ups follow the override or the plain pattern
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pad_pullup <= '0;
    end else begin
      pad_pullup <= next_pullup;
    end
  end

  // Gated pad level ahead of the port synchroniser; peripherals synchronise it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alt_logic_in <= '0;
    end else begin
      alt_logic_in <= gatedIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_input_sync <= '0;
    end else begin
      pin_input_sync <= pin_input_bit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      deep_rest_input_clamp <= 1'b0;
    end else begin
      deep_rest_input_clamp <= clampNow;
    end
  end

  // Analog link is a pad wire outside this block, no gating here

endmodule : port_pin_override_logic

// ### bench/port_override_sva.sv
`timescale 1ns/1ps
module port_override_sva #(parameter int PIN_COUNT = 8) (
  // Clock, reset, bus handshake, deep-sleep clamp
  input wire logic                 core_clk, rst_n, read, write, waitrequest, deep_rest_input_clamp,
  // Overrides and pads
  input wire logic [PIN_COUNT-1:0] pullup_override_en, pullup_override_val, drive_override_en, drive_override_val,
  input wire logic [PIN_COUNT-1:0] level_override_en, level_override_val, input_gate_override_en,
  input wire logic [PIN_COUNT-1:0] input_gate_override_val, ext_int_enable, pad_in, pad_out, pad_oe, pad_pullup,
  input wire logic [PIN_COUNT-1:0] alt_logic_in
);
  // Keeps $past away from values seen during reset
  logic live;
  always_ff @(posedge core_clk) live <= rst_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_pullup_ovr:
    assert property (live |-> ($past(pullup_override_en) & (pad_pullup ^ $past(pullup_override_val))) == '0)
    else $error("pull-up override");
  chk_drive_ovr:
    assert property (live |-> ($past(drive_override_en) & (pad_oe ^ $past(drive_override_val))) == '0)
    else $error("drive override");
  chk_level_ovr:
    assert property (live |-> ($past(level_override_en) & pad_oe & (pad_out ^ $past(level_override_val))) == '0)
    else $error("level override");
  chk_no_pullup_driven:
    assert property (live |-> ($past(~pullup_override_en & ~drive_override_en) & pad_oe & pad_pullup) == '0)
    else $error("pull-up on output");
  chk_wait_state:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  chk_wait_pulse:
    assert property (!waitrequest |=> waitrequest) else $error("long answer");
  chk_clamp_hold:
    assert property (live && $past(deep_rest_input_clamp) && deep_rest_input_clamp
      |-> (alt_logic_in & $past(~input_gate_override_en & ~ext_int_enable)) == '0) else $error("clamp");
  chk_gate_force:
    assert property (live |-> ($past(input_gate_override_en)
      & (alt_logic_in ^ $past(pad_in & input_gate_override_val))) == '0) else $error("input gate");
  cover property (write && !waitrequest);
  cover property (read && !waitrequest);
  cover property ($fell(deep_rest_input_clamp));
endmodule : port_override_sva
bind port_pin_override_logic port_override_sva #(.PIN_COUNT(PIN_COUNT)) sva (.core_clk, .rst_n, .read, .write,
  .waitrequest, .deep_rest_input_clamp, .pullup_override_en, .pullup_override_val, .drive_override_en,
  .drive_override_val, .level_override_en, .level_override_val, .input_gate_override_en, .input_gate_override_val,
  .ext_int_enable, .pad_in, .pad_out, .pad_oe, .pad_pullup, .alt_logic_in);

// ### bench/pad_partner.sv
`timescale 1ns/1ps
module pad_partner (
  // Block drive and board drive
  input wire logic       core_clk,
  input wire logic [7:0] padOut, padOe, padPullup, extEn, extVal,
  output logic     [7:0] padIn
);
  // Floating lines change every cycle so no stale level reads back
  logic [7:0] drift = 8'h5a;
  always @(posedge core_clk) drift <= ~drift;
  assign padIn = (padOe & padOut) | (~padOe & ((extEn & extVal) | (~extEn & (padPullup | drift))));
endmodule : pad_partner

// ### bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin failCount++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
  import port_override_pkg::*;
  logic       core_clk = 1'b0, rst_n, read, write, waitrequest, clamp;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata;
  // Slots: pull-up en/val, drive en/val, level en/val, invert, gate en/val, interrupt enable
  logic [7:0] ov [10];
  logic [7:0] extEn, extVal, padIn, padOut, padOe, padPullup, altIn, q, pinSync;
  int         failCount = 0, samplesChecked = 0;
  always #2 core_clk = ~core_clk;
  pad_partner partner (.core_clk, .padOut, .padOe, .padPullup, .extEn, .extVal, .padIn);
  port_pin_override_logic #(.PIN_COUNT(8)) dut (.core_clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .pullup_override_en(ov[0]), .pullup_override_val(ov[1]),
    .drive_override_en(ov[2]), .drive_override_val(ov[3]), .level_override_en(ov[4]), .level_override_val(ov[5]),
    .invert_override_en(ov[6]), .input_gate_override_en(ov[7]), .input_gate_override_val(ov[8]),
    .ext_int_enable(ov[9]), .pad_in(padIn), .pad_out(padOut), .pad_oe(padOe), .pad_pullup(padPullup),
    .alt_logic_in(altIn), .pin_input_sync(pinSync), .deep_rest_input_clamp(clamp));
  task finalReport;
    if (failCount == 0 && samplesChecked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finalReport
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wt
  task acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    address <= a; read <= !w; write <= w; writedata <= {24'h0, d};
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge core_clk);
      if (!waitrequest) begin
        done = 1'b1;
        q = readdata[7:0];
      end
    end
    read <= 1'b0; write <= 1'b0;
    if (!done) begin failCount++; finalReport(); end
  endtask : acc
  task tPlain;
    acc(DIR_OFFSET, 1'b0, 8'h00); `CHK(q, DIR_RESET)
    acc(DIR_OFFSET, 1'b1, 8'h0f); acc(OUT_OFFSET, 1'b1, 8'ha5); wt(2);
    `CHK(padOe, 8'h0f)
    `CHK(padOut, 8'h05)
    `CHK(padPullup, 8'ha0)
    acc(CTRL_OFFSET, 1'b1, 8'h01); wt(2); `CHK(padPullup, 8'h00)
    acc(CTRL_OFFSET, 1'b0, 8'h00); `CHK(q, 8'h01)
    acc(CTRL_OFFSET, 1'b1, 8'h00); acc(PIN_OFFSET, 1'b1, 8'h03); acc(OUT_OFFSET, 1'b0, 8'h00); `CHK(q, 8'ha6)
    wt(4); acc(PIN_OFFSET, 1'b0, 8'h00); `CHK(q, 8'hf6)
    `CHK(pinSync, 8'hf6)
    acc(4'h2, 1'b0, 8'h00); `CHK(q, 8'h00)
  endtask : tPlain
  task tOverride;
    @(posedge core_clk);
    ov[0] <= 8'hff; ov[1] <= 8'h3c; ov[2] <= 8'hf0; ov[3] <= 8'ha0; ov[4] <= 8'h80; wt(2);
    `CHK(padPullup, 8'h3c)
    `CHK(padOe, 8'haf)
    `CHK(padOut, 8'h26)
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) ov[i] <= '0;
    ov[6] <= 8'h01;
    @(posedge core_clk) ov[6] <= 8'h00;
    acc(OUT_OFFSET, 1'b0, 8'h00); `CHK(q, 8'ha7)
  endtask : tOverride
  task tSleep;
    ov[9] <= 8'h10;
    for (int m = 0; m < 6; m++) begin
      acc(CTRL_OFFSET, 1'b1, 8'(m << 4)); wt(2); `CHK(clamp, 1'(m >= 3))
    end
    wt(2); `CHK(altIn, 8'h10)
    @(posedge core_clk) begin ov[7] <= 8'h20; ov[8] <= 8'h20; end
    wt(3); `CHK(altIn, 8'h30)
    acc(CTRL_OFFSET, 1'b1, 8'h00); wt(4); `CHK(altIn, 8'hf7)
  endtask : tSleep
  initial begin
    rst_n <= 1'b0; address <= '0; read <= 1'b0; write <= 1'b0; writedata <= '0; byteenable <= 4'h1;
    extEn <= 8'hf0; extVal <= 8'hf0;
    for (int i = 0; i < 10; i++) ov[i] <= '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    tPlain(); tOverride(); tSleep(); finalReport();
  end
endmodule : tb_top
